// *** include/pchm_defs.vh ***
// Purpose: constants for the third-port handshake allocation block
// Assumes: 20 MHz reference clock, 8-bit host data bus
// Notes:   mode word and bit set/reset word follow the classic parallel-interface layout
`ifndef PCHM_DEFS_VH
`define PCHM_DEFS_VH

// Host register addresses (two address bits)
`define PCHM_ADDR_PORTC     2'h2
`define PCHM_ADDR_CTRL      2'h3
`define PCHM_ADDR_IRQ_STAT  2'h0
`define PCHM_ADDR_IRQ_MASK  2'h1

// Control word fields
`define PCHM_CW_MODE_SEL    7
`define PCHM_CW_A_MODE_HI   6
`define PCHM_CW_A_MODE_LO   5
`define PCHM_CW_A_DIR       4
`define PCHM_CW_CU_DIR      3
`define PCHM_CW_B_MODE      2
`define PCHM_CW_B_DIR       1
`define PCHM_CW_CL_DIR      0
`define PCHM_BSR_SEL_HI     3
`define PCHM_BSR_SEL_LO     1
`define PCHM_BSR_VAL        0

// Third-port bit positions
`define PCHM_B_IRQ          0
`define PCHM_B_BUF          1
`define PCHM_B_HS           2
`define PCHM_A_IRQ          3
`define PCHM_A_STB          4
`define PCHM_A_IBF          5
`define PCHM_A_ACK          6
`define PCHM_A_OBF          7

// Group A modes
`define PCHM_AMODE_BASIC    2'h0
`define PCHM_AMODE_STROBED  2'h1

// Reset values
`define PCHM_RST_BYTE       8'h00
`define PCHM_RST_CTRL       8'h9b
// Synchroniser stages start at the idle high pin level, so no false edge follows reset
`define PCHM_RST_SYNC       3'h7
`define PCHM_ALL_ONE        8'hff

// Interrupt status bits
`define PCHM_IRQ_B          0
`define PCHM_IRQ_A          1
`define PCHM_IRQ_MODE       2
`define PCHM_IRQ_W          3

// Enable flag one-hot codes: bit 0 group B, bit 1 group A input, bit 2 group A output
`define PCHM_FLAG_NONE      3'h0
`define PCHM_FLAG_B         3'h1
`define PCHM_FLAG_A_IN      3'h2
`define PCHM_FLAG_A_OUT     3'h4

`endif

// *** rtl/pchm_sync.v ***
// Purpose: three-stage synchroniser for one pin that qualifies a change once stages two and three agree
// Assumes: input is asynchronous to i_ref_clk
// Notes:   output changes only when stages two and three match, filtering one-cycle glitches
`timescale 1ns/10ps
`include "pchm_defs.vh"
module pchm_sync (
	// Clock and reset
	input  wire i_ref_clk,
	input  wire i_nrst,
	// Pin
	input  wire i_pin,
	// Qualified level
	output reg  o_level
);
	reg [2:0] sync_q;

	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			sync_q  <= `PCHM_RST_SYNC;
			o_level <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], i_pin};
			if (sync_q[1] == sync_q[2]) begin
				o_level <= sync_q[2];
			end
		end
	end
endmodule

// *** rtl/pchm_top.v ***
// Purpose: third-port line allocation for handshake, interrupt and plain I/O lines
// Assumes: single 20 MHz clock; host register port; handshake flags from the data-port logic arrive as inputs
// Notes:   strobe and acknowledge positions read back the enable flags, not the pins
// Behaviour
// R01: In basic mode each port C half is all input or all output.
// R02: Group B strobed input: bit0 irq, bit1 input full, bit2 strobe in.
// R03: Group B strobed output: bit0 irq, bit1 output full, bit2 acknowledge in.
// R04: Group A strobed input: bit3 irq, bit4 strobe, bit5 input full; 6,7 I/O.
// R05: Group A strobed output: bit3 irq, bit6 acknowledge, bit7 output full; 4,5 I/O.
// R06: Bidirectional: bits 3..7 irq, strobe, input full, acknowledge, output full.
// R07: Group B enable flag sits at bit position 2.
// R08: Group A input enable flag sits at bit position 4.
// R09: Group A output enable flag sits at bit position 6.
// R10: Port C read returns pins, but enable flags at strobe/acknowledge positions.
// R11: Bit set/reset on strobe/acknowledge positions changes the flag, not the line.
// R12: All enable flags clear on new mode selection and on reset.
// R13: Unclaimed lines follow their half's direction, latched outputs, unlatched inputs.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "pchm_defs.vh"
module pchm_top (
	// Clock and reset
	input  wire       i_ref_clk,
	input  wire       i_nrst,
	// Host register port
	input  wire [1:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	// Handshake status from the data-port logic
	input  wire       i_a_group_irq_out,
	input  wire       i_a_input_buffer_full,
	input  wire       i_a_output_buffer_full,
	input  wire       i_b_group_irq_out,
	input  wire       i_b_buffer_full,
	// Third port pins
	input  wire [7:0] i_third_port_line,
	output reg  [7:0] o_third_port_line,
	output reg  [7:0] o_third_port_oe,
	// Qualified handshake inputs and enable flags toward the data-port logic
	output reg        o_a_peripheral_strobe_n,
	output reg        o_a_ack_n,
	output reg        o_b_handshake_n,
	output reg        o_group_a_in_irq_enable,
	output reg        o_group_a_out_irq_enable,
	output reg        o_group_b_irq_enable,
	// Decoded modes
	output reg  [1:0] o_a_mode,
	output reg        o_a_dir_in,
	output reg        o_b_strobed,
	output reg        o_b_dir_in,
	// Interrupt
	output reg        o_irq
);
	reg  [7:0] ctrl_q;
	reg  [7:0] latch_q;
	reg  [2:0] irq_enable_flag_q;
	reg  [2:0] irq_stat_q;
	reg  [2:0] irq_mask_q;
	reg  [7:0] pin_q;
	reg  [1:0] irq_prev_q;
	wire [7:0] pin_lvl;

	// Per-pin synchronisers; pins are asynchronous to the reference clock
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			pchm_sync u_sync (
				.i_ref_clk (i_ref_clk),
				.i_nrst    (i_nrst),
				.i_pin     (i_third_port_line[gi]),
				.o_level   (pin_lvl[gi])
			);
		end
	endgenerate

	// Mode decode
	// Mode bit 6 wins over bit 5: both set still selects bidirectional
	wire       a_bidir   = ctrl_q[`PCHM_CW_A_MODE_HI];
	wire       a_strobed = ~a_bidir & ctrl_q[`PCHM_CW_A_MODE_LO];
	wire       a_in      = ctrl_q[`PCHM_CW_A_DIR];
	wire       b_strobed = ctrl_q[`PCHM_CW_B_MODE];
	wire       b_in      = ctrl_q[`PCHM_CW_B_DIR];
	wire       cu_in     = ctrl_q[`PCHM_CW_CU_DIR];
	wire       cl_in     = ctrl_q[`PCHM_CW_CL_DIR];
	wire       a_has_in  = a_bidir | (a_strobed & a_in);
	wire       a_has_out = a_bidir | (a_strobed & ~a_in);

	// Which lines are claimed by handshakes, and which are handshake inputs
	reg  [7:0] claim;
	reg  [7:0] hs_in;
	always @* begin
		claim = `PCHM_RST_BYTE;
		hs_in = `PCHM_RST_BYTE;
		if (b_strobed) begin
			claim[`PCHM_B_IRQ] = 1'b1; // see R02 see R03
			claim[`PCHM_B_BUF] = 1'b1;
			claim[`PCHM_B_HS]  = 1'b1;
			hs_in[`PCHM_B_HS]  = 1'b1;
		end
		if (a_bidir | a_strobed) begin
			claim[`PCHM_A_IRQ] = 1'b1; // see R04 see R05 see R06
		end
		if (a_has_in) begin
			claim[`PCHM_A_STB] = 1'b1;
			claim[`PCHM_A_IBF] = 1'b1;
			hs_in[`PCHM_A_STB] = 1'b1;
		end
		if (a_has_out) begin
			claim[`PCHM_A_ACK] = 1'b1;
			claim[`PCHM_A_OBF] = 1'b1;
			hs_in[`PCHM_A_ACK] = 1'b1;
		end
	end

	// Unclaimed lines take their half's direction from the mode word
	wire [7:0] half_out = {{4{~cu_in}}, {4{~cl_in}}}; // see R01 see R13
	wire [7:0] oe_d     = (claim & ~hs_in) | (~claim & half_out);

	// Handshake outputs; buffer-full outputs are active low on the output side
	reg  [7:0] hs_out;
	always @* begin
		hs_out = latch_q;
		hs_out[`PCHM_B_IRQ] = i_b_group_irq_out;
		// Group B line 1 is input full (high) in input mode, output full (low) in output mode
		hs_out[`PCHM_B_BUF] = b_in ? i_b_buffer_full : ~i_b_buffer_full;
		hs_out[`PCHM_A_IRQ] = i_a_group_irq_out;
		hs_out[`PCHM_A_IBF] = i_a_input_buffer_full;
		hs_out[`PCHM_A_OBF] = ~i_a_output_buffer_full;
	end
	wire [7:0] pout_d = (claim & hs_out) | (~claim & latch_q); // see R13

	// Read-back: enable flags replace strobe and acknowledge states
	function [7:0] portc_view;
		input [7:0] pins;
		input [7:0] outs;
		input [7:0] oe;
		input [7:0] hs;
		input [2:0] irq_enable_flag;
		reg   [7:0] v;
		begin
			// Output lines show what is driven, input lines the qualified pin
			v = (oe & outs) | (~oe & pins);
			if (hs[`PCHM_B_HS]) begin
				v[`PCHM_B_HS] = irq_enable_flag[0]; // see R10 see R07
			end
			if (hs[`PCHM_A_STB]) begin
				v[`PCHM_A_STB] = irq_enable_flag[1]; // see R10 see R08
			end
			if (hs[`PCHM_A_ACK]) begin
				v[`PCHM_A_ACK] = irq_enable_flag[2]; // see R10 see R09
			end
			portc_view = v;
		end
	endfunction

	// Host address decode, shared by the write, clear and read paths
	function [3:0] addr_dec;
		input [1:0] a;
		begin
			addr_dec = 4'h0;
			if (a == `PCHM_ADDR_IRQ_STAT) begin
				addr_dec[`PCHM_ADDR_IRQ_STAT] = 1'b1;
			end else if (a == `PCHM_ADDR_IRQ_MASK) begin
				addr_dec[`PCHM_ADDR_IRQ_MASK] = 1'b1;
			end else if (a == `PCHM_ADDR_PORTC) begin
				addr_dec[`PCHM_ADDR_PORTC] = 1'b1;
			end else begin
				addr_dec[`PCHM_ADDR_CTRL] = 1'b1;
			end
		end
	endfunction
	wire [3:0] sel = addr_dec(i_addr);

	// Which enable flag a third-port position holds; none away from the handshake input positions
	function [2:0] flag_at;
		input [2:0] pos;
		begin
			if (pos == `PCHM_B_HS) begin
				flag_at = `PCHM_FLAG_B; // see R07
			end else if (pos == `PCHM_A_STB) begin
				flag_at = `PCHM_FLAG_A_IN; // see R08
			end else if (pos == `PCHM_A_ACK) begin
				flag_at = `PCHM_FLAG_A_OUT; // see R09
			end else begin
				flag_at = `PCHM_FLAG_NONE;
			end
		end
	endfunction

	// Bit set/reset decode
	wire       wr_ctrl  = i_wr & sel[`PCHM_ADDR_CTRL];
	wire       mode_wr  = wr_ctrl & i_wdata[`PCHM_CW_MODE_SEL];
	wire       bsr_wr   = wr_ctrl & ~i_wdata[`PCHM_CW_MODE_SEL];
	wire [2:0] bsr_bit  = i_wdata[`PCHM_BSR_SEL_HI:`PCHM_BSR_SEL_LO];
	wire       bsr_val  = i_wdata[`PCHM_BSR_VAL];
	wire [2:0] bsr_flag = flag_at(bsr_bit);
	wire [7:0] bsr_hit  = 8'h01 << bsr_bit;
	wire       wr_portc = i_wr & sel[`PCHM_ADDR_PORTC];
	// Write to port C reaches basic-mode outputs only
	wire [7:0] basic_wmask = ~claim & half_out;

	// Events: each group's interrupt line rising, and a new mode selection
	// Rising edges only, so a line held high raises one event and not one per cycle
	wire [1:0] irq_now  = {i_a_group_irq_out, i_b_group_irq_out};
	wire [2:0] irq_ev   = {mode_wr, irq_now & ~irq_prev_q};
	wire       stat_rd  = i_rd & sel[`PCHM_ADDR_IRQ_STAT];

	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			ctrl_q     <= `PCHM_RST_CTRL;
			latch_q    <= `PCHM_RST_BYTE;
			irq_enable_flag_q     <= 3'h0; // see R12
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
			irq_prev_q <= 2'h0;
			pin_q      <= `PCHM_ALL_ONE;
		end else begin
			irq_prev_q <= irq_now;
			// Read-back sees the qualified level one cycle late, never a half-taken change
			pin_q      <= pin_lvl;
			if (mode_wr) begin
				// A new mode starts from a clean latch, so stale values never reach freshly claimed lines
				ctrl_q  <= i_wdata;
				latch_q <= `PCHM_RST_BYTE;
				irq_enable_flag_q  <= 3'h0; // see R12
			end else if (bsr_wr) begin
				if (hs_in[bsr_bit]) begin
					// Flag only; the input line itself is left alone
					irq_enable_flag_q <= (irq_enable_flag_q & ~bsr_flag) | (bsr_val ? bsr_flag : `PCHM_FLAG_NONE); // see R11
				end else begin
					latch_q <= (latch_q & ~bsr_hit) | (bsr_val ? bsr_hit : `PCHM_RST_BYTE);
				end
			end else if (wr_portc) begin
				latch_q <= (latch_q & ~basic_wmask) | (i_wdata & basic_wmask);
			end
			if (i_wr & sel[`PCHM_ADDR_IRQ_MASK]) begin
				irq_mask_q <= i_wdata[`PCHM_IRQ_W-1:0];
			end
			// Set wins over the read-clear, so an event in the clearing cycle is not lost
			if (stat_rd) begin
				irq_stat_q <= irq_ev;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
		end
	end

	// Registered outputs
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_third_port_line        <= `PCHM_RST_BYTE;
			o_third_port_oe          <= `PCHM_RST_BYTE;
			o_a_peripheral_strobe_n  <= 1'b1;
			o_a_ack_n                <= 1'b1;
			o_b_handshake_n          <= 1'b1;
			o_group_a_in_irq_enable  <= 1'b0;
			o_group_a_out_irq_enable <= 1'b0;
			o_group_b_irq_enable     <= 1'b0;
			o_a_mode                 <= `PCHM_AMODE_BASIC;
			o_a_dir_in               <= 1'b1;
			o_b_strobed              <= 1'b0;
			o_b_dir_in               <= 1'b1;
			o_irq                    <= 1'b0;
		end else begin
			o_third_port_line        <= pout_d;
			o_third_port_oe          <= oe_d;
			// Unclaimed handshake inputs read as idle, so the data-port logic never sees a stray strobe
			o_a_peripheral_strobe_n  <= a_has_in ? pin_lvl[`PCHM_A_STB] : 1'b1;
			o_a_ack_n                <= a_has_out ? pin_lvl[`PCHM_A_ACK] : 1'b1;
			o_b_handshake_n          <= b_strobed ? pin_lvl[`PCHM_B_HS] : 1'b1;
			o_group_b_irq_enable     <= irq_enable_flag_q[0];
			o_group_a_in_irq_enable  <= irq_enable_flag_q[1];
			o_group_a_out_irq_enable <= irq_enable_flag_q[2];
			o_a_mode                 <= ctrl_q[`PCHM_CW_A_MODE_HI:`PCHM_CW_A_MODE_LO];
			o_a_dir_in               <= a_in;
			o_b_strobed              <= b_strobed;
			o_b_dir_in               <= b_in;
			o_irq                    <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read data stand for one cycle only; idle zero keeps the bus quiet between reads
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_rdata <= `PCHM_RST_BYTE;
		end else if (i_rd) begin
			if (sel[`PCHM_ADDR_PORTC]) begin
				o_rdata <= portc_view(pin_q, o_third_port_line, o_third_port_oe, hs_in, irq_enable_flag_q);
			end else if (sel[`PCHM_ADDR_IRQ_STAT]) begin
				o_rdata <= {5'h00, irq_stat_q};
			end else if (sel[`PCHM_ADDR_IRQ_MASK]) begin
				o_rdata <= {5'h00, irq_mask_q};
			end else begin
				o_rdata <= ctrl_q;
			end
		end else begin
			o_rdata <= `PCHM_RST_BYTE;
		end
	end
endmodule

// *** test/pchm_props.sv ***
// Purpose: port checks for third-port line allocation
// Assumes: one clock, synchronous active-low reset
// Notes:   direction checks wait one settled cycle, so decode skew is tolerated
`timescale 1ns/10ps
module pchm_props (
	input logic       i_ref_clk,
	input logic       i_nrst,
	input logic [1:0] i_addr,
	input logic [7:0] i_wdata,
	input logic       i_wr,
	input logic       i_rd,
	input logic [7:0] o_rdata,
	input logic [7:0] o_third_port_oe,
	input logic       o_group_a_in_irq_enable,
	input logic       o_group_a_out_irq_enable,
	input logic       o_group_b_irq_enable,
	input logic [1:0] o_a_mode,
	input logic       o_a_dir_in,
	input logic       o_b_strobed,
	input logic       o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	logic [1:0] wr_hist_q;
	logic       ctl;
	logic       quiet;
	always_ff @(posedge i_ref_clk) begin
		wr_hist_q <= {wr_hist_q[0], i_wr};
	end
	// A mode word still in flight would make the decoded mode stale
	assign quiet = (wr_hist_q == 2'h0);
	assign ctl = i_wr && (i_addr == 2'h3) && quiet;
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
	a_mode_clear: assert property (ctl && i_wdata[7] |-> ##2 !(o_group_a_in_irq_enable ||
		o_group_a_out_irq_enable || o_group_b_irq_enable)) else $error("flags kept over mode word");
	a_b_flag_set: assert property (ctl && i_wdata == 8'h05 && o_b_strobed |-> ##2 o_group_b_irq_enable)
		else $error("group b flag not set");
	a_ain_flag_set: assert property (ctl && i_wdata == 8'h09 && (o_a_mode[1] || o_a_mode == 2'h1 && o_a_dir_in)
		|-> ##2 o_group_a_in_irq_enable) else $error("group a input flag not set");
	a_aout_flag_set: assert property (ctl && i_wdata == 8'h0d && (o_a_mode[1] || o_a_mode == 2'h1 && !o_a_dir_in)
		|-> ##2 o_group_a_out_irq_enable) else $error("group a output flag not set");
	a_b_lines: assert property (o_b_strobed && $past(o_b_strobed) |-> o_third_port_oe[2:0] == 3'h3)
		else $error("group b lines misdirected");
	a_a_strobed: assert property (o_a_mode == 2'h1 && $stable(o_a_mode) && $stable(o_a_dir_in)
		|-> o_third_port_oe[3] && (o_a_dir_in ? o_third_port_oe[5:4] == 2'h2 : o_third_port_oe[7:6] == 2'h2))
		else $error("group a strobed lines misdirected");
	a_bidir_lines: assert property (o_a_mode[1] && $stable(o_a_mode) |-> o_third_port_oe[7:3] == 5'h15)
		else $error("bidirectional lines misdirected");
	a_basic_half: assert property (o_a_mode == 2'h0 && $stable(o_a_mode) && $stable(o_third_port_oe)
		|-> o_third_port_oe[7:4] inside {4'h0, 4'hf}) else $error("upper half split");
	a_irq_masked: assert property (i_wr && i_addr == 2'h1 && i_wdata == 8'h00 |-> ##2 !o_irq)
		else $error("masked interrupt still high");
	c_mode_word: cover property (ctl && i_wdata[7]);
	c_flag_set: cover property (o_group_b_irq_enable);
	c_irq_high: cover property (o_irq);
endmodule
bind pchm_top pchm_props u_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_third_port_oe(o_third_port_oe),
	.o_group_a_in_irq_enable(o_group_a_in_irq_enable), .o_group_a_out_irq_enable(o_group_a_out_irq_enable),
	.o_group_b_irq_enable(o_group_b_irq_enable), .o_a_mode(o_a_mode), .o_a_dir_in(o_a_dir_in),
	.o_b_strobed(o_b_strobed), .o_irq(o_irq));

// *** test/pchm_periph.sv ***
// Purpose: peripheral side of the third port
// Assumes: peripheral drives every line the block leaves undriven
// Notes:   handshake lines idle high; the bench pulls chosen lines low
`timescale 1ns/10ps
module pchm_periph (
	input  logic [7:0] i_oe,
	input  logic [7:0] i_dout,
	input  logic [7:0] i_pull_low,
	output logic [7:0] o_pins
);
	assign o_pins = (i_oe & i_dout) | (~i_oe & ~i_pull_low);
endmodule

// *** test/pchm_top_tb.sv ***
// Purpose: self-checking bench for third-port line allocation
// Assumes: 20 MHz clock, host port strobes one cycle wide
// Notes:   writes are spaced so decoded modes settle before the next one
`timescale 1ns/10ps
module pchm_top_tb;
	logic       i_ref_clk = 1'b0;
	logic       i_nrst = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic       a_irq = 1'b0, a_ibf = 1'b0, a_obf = 1'b0, b_irq = 1'b0, b_buf = 1'b0;
	logic [7:0] pull_low = 8'h00;
	logic [7:0] got;
	wire  [7:0] pins, rdata, dout, oe;
	wire  [1:0] a_mode;
	wire        stb_n, ack_n, hs_n, f_ain, f_aout, f_b, b_str, b_in, a_in, irq;
	int         fail_count = 0;
	int         compares = 0;
	always #25 i_ref_clk = ~i_ref_clk;
	pchm_top DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(rdata), .i_a_group_irq_out(a_irq), .i_a_input_buffer_full(a_ibf),
		.i_a_output_buffer_full(a_obf), .i_b_group_irq_out(b_irq), .i_b_buffer_full(b_buf),
		.i_third_port_line(pins), .o_third_port_line(dout), .o_third_port_oe(oe), .o_a_peripheral_strobe_n(stb_n),
		.o_a_ack_n(ack_n), .o_b_handshake_n(hs_n), .o_group_a_in_irq_enable(f_ain),
		.o_group_a_out_irq_enable(f_aout), .o_group_b_irq_enable(f_b), .o_a_mode(a_mode), .o_a_dir_in(a_in),
		.o_b_strobed(b_str), .o_b_dir_in(b_in), .o_irq(irq));
	pchm_periph u_periph (.i_oe(oe), .i_dout(dout), .i_pull_low(pull_low), .o_pins(pins));
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		settle(2);
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic t_basic;
		cmp({oe[7:0]}, 8'h00);
		cmp({5'h0, f_aout, f_ain, f_b}, 8'h00);
		wr(2'h3, 8'h80);
		cmp(oe, 8'hff);
		wr(2'h2, 8'ha5);
		cmp(dout, 8'ha5);
		rd(2'h2);
		cmp(got, 8'ha5);
		wr(2'h3, 8'h88);
		cmp(oe, 8'h0f);
		pull_low <= 8'h50;
		settle(6);
		rd(2'h2);
		cmp({4'h0, got[7:4]}, 8'h0a);
		$display("basic done");
	endtask
	task automatic t_aout_bin;
		pull_low <= 8'h00;
		wr(2'h3, 8'ha6);
		cmp(oe, 8'hbb);
		cmp({3'h0, a_mode, a_in, b_str, b_in}, 8'h0b);
		b_buf <= 1'b1;
		b_irq <= 1'b1;
		a_irq <= 1'b1;
		settle(3);
		cmp({5'h0, dout[3], dout[1:0]}, 8'h07);
		wr(2'h3, 8'h05);
		wr(2'h3, 8'h0d);
		cmp({6'h0, f_aout, f_b}, 8'h03);
		cmp(oe, 8'hbb);
		pull_low <= 8'h44;
		settle(6);
		cmp({6'h0, ack_n, hs_n}, 8'h00);
		rd(2'h2);
		cmp({6'h0, got[6], got[2]}, 8'h03);
		pull_low <= 8'h00;
		wr(2'h3, 8'h04);
		rd(2'h2);
		cmp({7'h0, got[2]}, 8'h00);
		$display("strobed output done");
	endtask
	task automatic t_ain_bidir;
		b_irq <= 1'b0;
		a_ibf <= 1'b1;
		a_obf <= 1'b1;
		wr(2'h3, 8'hb4);
		cmp({5'h0, f_aout, f_ain, f_b}, 8'h00);
		cmp(oe, 8'heb);
		cmp({3'h0, a_mode, a_in, b_str, b_in}, 8'h0e);
		cmp({7'h0, dout[5]}, 8'h01);
		wr(2'h3, 8'h09);
		cmp({7'h0, f_ain}, 8'h01);
		pull_low <= 8'h10;
		settle(6);
		cmp({7'h0, stb_n}, 8'h00);
		wr(2'h3, 8'hc0);
		cmp(oe, 8'haf);
		cmp({3'h0, a_mode, a_in, b_str, b_in}, 8'h10);
		wr(2'h3, 8'h09);
		wr(2'h3, 8'h0d);
		cmp({6'h0, f_aout, f_ain}, 8'h03);
		pull_low <= 8'h50;
		rd(2'h2);
		cmp({6'h0, got[6], got[4]}, 8'h03);
		$display("strobed input and bidirectional done");
	endtask
	task automatic t_irq;
		rd(2'h0);
		wr(2'h1, 8'h05);
		cmp({7'h0, irq}, 8'h00);
		wr(2'h3, 8'h80);
		cmp({7'h0, irq}, 8'h01);
		rd(2'h0);
		cmp(got, 8'h04);
		settle(2);
		cmp({7'h0, irq}, 8'h00);
		b_irq <= 1'b1;
		settle(3);
		cmp({7'h0, irq}, 8'h01);
		rd(2'h0);
		cmp(got, 8'h01);
		wr(2'h1, 8'h00);
		cmp({7'h0, irq}, 8'h00);
		$display("interrupt done");
	endtask
	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		settle(1);
		t_basic;
		t_aout_bin;
		t_ain_bidir;
		t_irq;
		final_report;
	end
	initial begin
		repeat (2000) @(posedge i_ref_clk);
		fail_count++;
		final_report;
	end
endmodule
